// ==== logic/trace_port_pkg.sv ====
`default_nettype none
package trace_port_pkg;

    // Register offsets on the peripheral bus
    localparam logic [7:0] OFS_TRACE_BYTE = 8'h00;
    localparam logic [7:0] OFS_TRACE_CONTROL = 8'h04;

    // Control field positions
    localparam int CTRL_FALL_LAUNCH_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 1;

    // Values after reset, control write mask and unmapped read value
    localparam logic [7:0] TRACE_BYTE_RESET = 8'h00;
    localparam logic [7:0] TRACE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TRACE_CONTROL_WMASK = 8'h03;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Trace clock timing, half a bit period
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_BIT_NS = 20;
    localparam int HALF_BIT_CYCLES_RAW = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_BIT_CYCLES = (HALF_BIT_CYCLES_RAW < 1) ? 1 : HALF_BIT_CYCLES_RAW;
    localparam logic [3:0] HALF_DIV_LAST = 4'(HALF_BIT_CYCLES - 1);
    localparam logic [3:0] HALF_DIV_RESET = 4'h0;

    // Last half-period index for each launch edge
    localparam logic [4:0] LAST_HALF_RISE_LAUNCH = 5'h10;
    localparam logic [4:0] LAST_HALF_FALL_LAUNCH = 5'h0F;
    localparam logic [4:0] HALF_RESET = 5'h00;

    localparam int FIFO_DEPTH = 2;
    localparam logic [1:0] FIFO_FULL_COUNT = 2'h2;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_RUN = 2'b01
    } shift_state_t;

endpackage
`default_nettype wire

// ==== logic/trace_stream_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface trace_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;

    modport src (
        output valid,
        output data,
        input ready
    );

    modport snk (
        input valid,
        input data,
        output ready
    );
endinterface
`default_nettype wire

// ==== logic/trace_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module trace_fifo (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    trace_stream_if.src out
);
    typedef struct packed {
        logic [trace_port_pkg::FIFO_DEPTH-1:0][7:0] mem;
        logic wptr;
        logic rptr;
        logic [1:0] count;
    } fifo_state_t;

    fifo_state_t s_ff;
    fifo_state_t nxt_s;
    logic push;
    logic pop;

    assign in_ready = (s_ff.count != trace_port_pkg::FIFO_FULL_COUNT);
    assign out.valid = (s_ff.count != 2'h0);
    assign out.data = s_ff.mem[s_ff.rptr];

    always_comb begin
        nxt_s = s_ff;
        push = in_valid && in_ready;
        pop = out.valid && out.ready;
        if (push) begin
            nxt_s.mem[s_ff.wptr] = in_data;
            nxt_s.wptr = ~s_ff.wptr;
        end
        if (pop) begin
            nxt_s.rptr = ~s_ff.rptr;
        end
        nxt_s.count = 2'(s_ff.count + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule
`default_nettype wire

// ==== logic/trace_shifter.sv ====
`timescale 1ns/100ps
`default_nettype none
module trace_shifter (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic fall_launch,
    trace_stream_if.snk in,
    output logic shift_busy,
    output logic ser_clk,
    output logic ser_dat
);
    typedef struct packed {
        trace_port_pkg::shift_state_t st;
        logic [7:0] shreg;
        logic fall;
        logic [4:0] half;
        logic [3:0] div;
        logic clk;
        logic dat;
    } shift_t;

    shift_t s_ff;
    shift_t nxt_s;
    logic [4:0] nxt_half;
    logic [4:0] prev_half;
    logic [4:0] last_half;
    logic [2:0] bit_idx;

    assign shift_busy = (s_ff.st == trace_port_pkg::SH_RUN);
    assign ser_clk = s_ff.clk;
    assign ser_dat = s_ff.dat;

    always_comb begin
        nxt_s = s_ff;
        in.ready = 1'b0;
        nxt_half = 5'(s_ff.half + 5'h01);
        prev_half = s_ff.half;
        last_half = s_ff.fall ? trace_port_pkg::LAST_HALF_FALL_LAUNCH
                              : trace_port_pkg::LAST_HALF_RISE_LAUNCH;
        // Launch index: falling mode one bit per half pair from 0, rising mode lags a half
        bit_idx = s_ff.fall ? nxt_half[3:1] : prev_half[3:1];
        unique case (s_ff.st)
            trace_port_pkg::SH_IDLE: begin
                nxt_s.clk = 1'b1;
                nxt_s.dat = 1'b1;
                if (in.valid) begin
                    in.ready = 1'b1;
                    nxt_s.st = trace_port_pkg::SH_RUN;
                    nxt_s.shreg = in.data;
                    nxt_s.fall = fall_launch;
                    nxt_s.half = trace_port_pkg::HALF_RESET;
                    nxt_s.div = trace_port_pkg::HALF_DIV_RESET;
                    nxt_s.clk = 1'b0;
                    nxt_s.dat = fall_launch ? in.data[0] : 1'b1;
                end
            end
            trace_port_pkg::SH_RUN: begin
                if (s_ff.div == trace_port_pkg::HALF_DIV_LAST) begin
                    nxt_s.div = trace_port_pkg::HALF_DIV_RESET;
                    if (s_ff.half == last_half) begin
                        nxt_s.st = trace_port_pkg::SH_IDLE;
                        nxt_s.clk = 1'b1;
                        nxt_s.dat = 1'b1;
                    end else begin
                        nxt_s.half = nxt_half;
                        nxt_s.clk = nxt_half[0];
                        // Data moves only on the launch edge, holds across the sample edge
                        if (nxt_half[0] == ~s_ff.fall) begin
                            nxt_s.dat = s_ff.shreg[bit_idx];
                        end
                    end
                end else begin
                    nxt_s.div = 4'(s_ff.div + 4'h1);
                end
            end
            default: begin
                nxt_s.st = trace_port_pkg::SH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= '{st: trace_port_pkg::SH_IDLE, shreg: 8'h00, fall: 1'b0, half: 5'h00,
                      div: 4'h0, clk: 1'b1, dat: 1'b1};
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule
`default_nettype wire

// ==== logic/trace_port.sv ====
// Contract
// - Data register write starts one byte transfer
// - One byte per transfer, LSB first
// - Transmit only, nothing received
// - Edge select: 0 rising, 1 falling launch
// - Bit stable for opposite sampling edge
// - Idle drives clock and data high
// - Timing and trace clock from bus clock
// - Stall data writes until transfer completes
// - Data read returns last write, 00h reset
// - Enable bit gates trace clock, default off
// - Clock request only when enabled and busy
// - Idle when no transfer; no status bit
// - No interrupt output at all
// - Reset clears registers, outputs idle
`timescale 1ns/100ps
`default_nettype none
module trace_port (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic pb_sel,
    input wire logic pb_wr,
    input wire logic [7:0] pb_addr,
    input wire logic [7:0] pb_wdata,
    output logic [7:0] pb_rdata,
    output logic pb_ready,
    output logic trace_clk_out,
    output logic trace_data_out,
    output logic clk_req
);
    typedef struct packed {
        logic [7:0] trace_byte;
        logic [7:0] trace_control;
        logic [7:0] rdata;
        logic ready;
        logic clk_pin;
        logic dat_pin;
        logic req;
    } port_state_t;

    port_state_t s_ff;
    port_state_t nxt_s;
    logic fifo_push;
    logic fifo_in_ready;
    logic shift_busy;
    logic ser_clk;
    logic ser_dat;
    logic port_busy;
    logic port_en;

    trace_stream_if stream ();

    trace_fifo u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(pb_wdata),
        .out(stream.src)
    );

    trace_shifter u_shifter (
        .mclk(mclk),
        .arst_n(arst_n),
        .fall_launch(s_ff.trace_control[trace_port_pkg::CTRL_FALL_LAUNCH_BIT]),
        .in(stream.snk),
        .shift_busy(shift_busy),
        .ser_clk(ser_clk),
        .ser_dat(ser_dat)
    );

    // Busy while a byte waits or shifts; idle otherwise, never visible as a bit
    assign port_busy = stream.valid || shift_busy;
    assign port_en = s_ff.trace_control[trace_port_pkg::CTRL_ENABLE_BIT];

    // Outputs are registered; only pins outward, no receive path and no interrupt
    assign pb_rdata = s_ff.rdata;
    assign pb_ready = s_ff.ready;
    assign trace_clk_out = s_ff.clk_pin;
    assign trace_data_out = s_ff.dat_pin;
    assign clk_req = s_ff.req;

    always_comb begin
        nxt_s = s_ff;
        fifo_push = 1'b0;
        nxt_s.ready = 1'b0;
        // One access per select; ready pulse blocks a repeat on the same request
        if (pb_sel && !s_ff.ready) begin
            unique case (pb_addr)
                trace_port_pkg::OFS_TRACE_BYTE: begin
                    if (pb_wr) begin
                        if (!port_busy && fifo_in_ready) begin
                            nxt_s.trace_byte = pb_wdata;
                            fifo_push = 1'b1;
                            nxt_s.ready = 1'b1;
                            nxt_s.rdata = trace_port_pkg::UNMAPPED_READ;
                        end
                    end else begin
                        nxt_s.rdata = s_ff.trace_byte;
                        nxt_s.ready = 1'b1;
                    end
                end
                trace_port_pkg::OFS_TRACE_CONTROL: begin
                    if (pb_wr) begin
                        nxt_s.trace_control = pb_wdata & trace_port_pkg::TRACE_CONTROL_WMASK;
                        nxt_s.rdata = trace_port_pkg::UNMAPPED_READ;
                    end else begin
                        nxt_s.rdata = s_ff.trace_control;
                    end
                    nxt_s.ready = 1'b1;
                end
                default: begin
                    nxt_s.rdata = trace_port_pkg::UNMAPPED_READ;
                    nxt_s.ready = 1'b1;
                end
            endcase
        end
        // Disabled port holds the clock pin high
        nxt_s.clk_pin = port_en ? ser_clk : 1'b1;
        nxt_s.dat_pin = ser_dat;
        nxt_s.req = port_en && port_busy;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= '{trace_byte: trace_port_pkg::TRACE_BYTE_RESET,
                      trace_control: trace_port_pkg::TRACE_CONTROL_RESET,
                      rdata: 8'h00, ready: 1'b0, clk_pin: 1'b1, dat_pin: 1'b1,
                      req: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule
`default_nettype wire

// ==== tb/trace_rx.sv ====
`timescale 1ns/100ps
`default_nettype none
module trace_rx (
    input wire logic clk_in,
    input wire logic dat_in,
    input wire logic fall_launch,
    output logic [7:0] byte_q,
    output int cnt
);
    initial begin
        byte_q = 8'h00;
        cnt = 0;
    end
    // Samples on the edge opposite the launch edge, never drives back
    always @(clk_in) begin
        if (clk_in == fall_launch) begin
            byte_q <= {dat_in, byte_q[7:1]};
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/trace_port_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module trace_port_chk (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic pb_sel,
    input wire logic pb_wr,
    input wire logic [7:0] pb_addr,
    input wire logic [7:0] pb_wdata,
    input wire logic [7:0] pb_rdata,
    input wire logic pb_ready,
    input wire logic trace_clk_out,
    input wire logic trace_data_out,
    input wire logic clk_req
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic en_ff;
    logic edge_ff;
    logic [7:0] last_ff;
    logic [5:0] gap_ff;
    wire logic rd = pb_ready && pb_sel && !pb_wr;
    wire logic cw = pb_ready && pb_sel && pb_wr && pb_addr == 8'h04;
    wire logic dw = pb_ready && pb_sel && pb_wr && pb_addr == 8'h00;
    // Shadow of control and data as firmware last wrote them
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            en_ff <= 1'b0;
            edge_ff <= 1'b0;
            last_ff <= 8'h00;
            gap_ff <= 6'h3F;
        end else begin
            en_ff <= cw ? pb_wdata[1] : en_ff;
            edge_ff <= cw ? pb_wdata[0] : edge_ff;
            last_ff <= dw ? pb_wdata : last_ff;
            gap_ff <= dw ? 6'h00 : (gap_ff == 6'h3F ? gap_ff : gap_ff + 6'h01);
        end
    end
    property p_rdy_pulse;
        pb_ready |=> !pb_ready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
    property p_stall;
        dw |-> gap_ff >= 6'h1C;
    endproperty
    a_stall: assert property (p_stall) else $error("data write not held off");
    property p_data_rd;
        rd && pb_addr == 8'h00 |-> pb_rdata == last_ff;
    endproperty
    a_data_rd: assert property (p_data_rd) else $error("data readback");
    property p_unmapped;
        rd && pb_addr != 8'h00 && pb_addr != 8'h04 |-> pb_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_clk_gated;
        !en_ff |-> trace_clk_out;
    endproperty
    a_clk_gated: assert property (p_clk_gated) else $error("clock not gated");
    property p_req_en;
        clk_req |-> en_ff;
    endproperty
    a_req_en: assert property (p_req_en) else $error("request while disabled");
    property p_req_start;
        en_ff && dw |-> ##[1:4] clk_req;
    endproperty
    a_req_start: assert property (p_req_start) else $error("no request");
    property p_idle_end;
        $fell(clk_req) |-> trace_clk_out && trace_data_out;
    endproperty
    a_idle_end: assert property (p_idle_end) else $error("pins not idle");
    property p_launch_rise;
        en_ff && !edge_ff && $changed(trace_data_out) |-> $rose(trace_clk_out);
    endproperty
    a_launch_rise: assert property (p_launch_rise) else $error("rise launch");
    property p_launch_fall;
        en_ff && edge_ff && $changed(trace_data_out) |-> !trace_clk_out || $past(trace_clk_out);
    endproperty
    a_launch_fall: assert property (p_launch_fall) else $error("fall launch");
endmodule
bind trace_port trace_port_chk u_chk (
    .mclk(mclk),
    .arst_n(arst_n),
    .pb_sel(pb_sel),
    .pb_wr(pb_wr),
    .pb_addr(pb_addr),
    .pb_wdata(pb_wdata),
    .pb_rdata(pb_rdata),
    .pb_ready(pb_ready),
    .trace_clk_out(trace_clk_out),
    .trace_data_out(trace_data_out),
    .clk_req(clk_req)
);
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk, arst_n, pb_sel, pb_wr, pb_ready, trace_clk_out, trace_data_out, clk_req;
    logic saw_req, fall_sel;
    logic [7:0] pb_addr, pb_wdata, pb_rdata, q, rx_byte;
    int rx_cnt, c0, n, failures, tests_run;
    trace_port dut (.mclk(mclk), .arst_n(arst_n), .pb_sel(pb_sel), .pb_wr(pb_wr),
        .pb_addr(pb_addr), .pb_wdata(pb_wdata), .pb_rdata(pb_rdata), .pb_ready(pb_ready),
        .trace_clk_out(trace_clk_out), .trace_data_out(trace_data_out), .clk_req(clk_req));
    trace_rx rx (.clk_in(trace_clk_out), .dat_in(trace_data_out), .fall_launch(fall_sel),
        .byte_q(rx_byte), .cnt(rx_cnt));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) if (clk_req === 1'b1) saw_req <= 1'b1;
    task complete_run;
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask
    // Looks at ready mid-cycle, holds the request through the edge that samples it
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        pb_sel = 1'b1;
        pb_wr = w;
        pb_addr = a;
        pb_wdata = d;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (pb_ready !== 1'b1 && n < 99);
        q = pb_rdata;
        chk("ready", 8'h01, {7'h00, pb_ready});
        @(posedge mclk);
        #1 pb_sel = 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task idle_pins;
        chk("pins", 8'h03, {6'h00, trace_clk_out, trace_data_out});
        chk("req", 8'h00, {7'h00, clk_req});
    endtask
    task t_reset_vals;
        bus(1'b0, 8'h00, 8'h00);
        chk("data_rst", 8'h00, q);
        bus(1'b0, 8'h04, 8'h00);
        chk("ctrl_rst", 8'h00, q);
        idle_pins();
    endtask
    task t_regs;
        bus(1'b1, 8'h04, 8'hFF);
        bus(1'b0, 8'h04, 8'h00);
        chk("ctrl_mask", 8'h03, q);
        bus(1'b1, 8'h08, 8'h5A);
        bus(1'b0, 8'h08, 8'h00);
        chk("unmapped", 8'h00, q);
        bus(1'b0, 8'h04, 8'h00);
        chk("ctrl_keep", 8'h03, q);
    endtask
    task t_xfer(input logic fall, input logic [7:0] b);
        fall_sel = fall;
        bus(1'b1, 8'h04, {6'h00, 1'b1, fall});
        c0 = rx_cnt;
        saw_req = 1'b0;
        bus(1'b1, 8'h00, ~b);
        bus(1'b1, 8'h00, b);
        chk("stall", 8'h01, 8'(n > 25));
        repeat (40) @(posedge mclk);
        #1;
        chk("rx_byte", b, rx_byte);
        // Rising launch gives one extra sample before bit0
        chk("rx_bits", fall ? 8'h10 : 8'h12, 8'(rx_cnt - c0));
        chk("req_seen", 8'h01, {7'h00, saw_req});
        bus(1'b0, 8'h00, 8'h00);
        chk("data_rb", b, q);
        idle_pins();
    endtask
    task t_off;
        fall_sel = 1'b0;
        bus(1'b1, 8'h04, 8'h00);
        c0 = rx_cnt;
        saw_req = 1'b0;
        bus(1'b1, 8'h00, 8'h96);
        repeat (40) @(posedge mclk);
        #1;
        chk("off_bits", 8'h00, 8'(rx_cnt - c0));
        chk("off_req", 8'h00, {7'h00, saw_req});
        bus(1'b0, 8'h00, 8'h00);
        chk("off_rb", 8'h96, q);
    endtask
    task t_mid_reset;
        bus(1'b1, 8'h04, 8'h02);
        bus(1'b1, 8'h00, 8'hC3);
        repeat (9) @(posedge mclk);
        #1 arst_n = 1'b0;
        @(posedge mclk);
        #1 arst_n = 1'b1;
        idle_pins();
        t_reset_vals();
    endtask
    initial begin
        #100000;
        failures++;
        complete_run();
    end
    initial begin
        arst_n = 1'b0;
        {pb_sel, pb_wr, pb_addr, pb_wdata, fall_sel, saw_req} = 20'h00000;
        repeat (12) @(posedge mclk);
        #1 arst_n = 1'b1;
        t_reset_vals();
        t_regs();
        t_xfer(1'b0, 8'hA5);
        t_xfer(1'b1, 8'h3C);
        t_off();
        t_mid_reset();
        complete_run();
    end
endmodule
`default_nettype wire
